// file: serial_port_pkg.sv
// Constants shared by the serial port core: register map, fields, resets.
// Assumes one 100 MHz bus clock; all serial timing is derived by enables.
package serial_port_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DIV_INT = 8'h08;
    localparam logic [7:0] OFS_DIV_FRAC = 8'h0C;
    localparam logic [7:0] OFS_LINE_CTRL = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;
    localparam logic [7:0] OFS_INT_RAW = 8'h1C;
    localparam logic [7:0] OFS_INT_MASKED = 8'h20;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h24;
    localparam logic [7:0] OFS_DMA_CTRL = 8'h28;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LC_BREAK = 0;
    localparam int LC_PAR_EN = 1;
    localparam int LC_PAR_EVEN = 2;
    localparam int LC_TWO_STOP = 3;
    localparam int LC_FIFO_EN = 4;
    localparam int LC_WLEN_LO = 5;
    localparam int CT_ENABLE = 0;
    localparam int CT_TX_EN = 8;
    localparam int CT_RX_EN = 9;
    localparam int CT_RTS = 11;
    localparam int CT_RTS_FLOW = 14;
    localparam int CT_CTS_FLOW = 15;
    // Interrupt bits: 0 cts change, 1 rx, 2 tx, 3 rx timeout, 4..7 fe pe be oe
    localparam int IRQ_BITS = 8;
    localparam int IRQ_MS = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_TX = 2;
    localparam int IRQ_RT = 3;
    localparam int IRQ_FE = 4;
    localparam int IRQ_OE = 7;

    // ------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [15:0] DIV_INT_RST = 16'h0000;
    localparam logic [5:0] DIV_FRAC_RST = 6'h00;
    localparam logic [7:0] LINE_CTRL_RST = 8'h00;
    localparam logic [15:0] CTRL_RST = 16'h0300;
    localparam int TICKS_PER_BIT = 16;
    localparam int START_CHECK_TICK = 8;
    localparam int RX_TIMEOUT_BITS = 32;
    localparam int RX_TIMEOUT_TICKS = RX_TIMEOUT_BITS * TICKS_PER_BIT;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_START = 3'b001,
        SER_DATA = 3'b010,
        SER_PARITY = 3'b011,
        SER_STOP = 3'b100
    } ser_state_e;

endpackage

// file: serial_port_core.sv
// Asynchronous serial port with FIFOs, fractional rate generator, flow
// control, interrupt masking and DMA requests behind an AHB-Lite slave.
// Assumes one clock; serial pins are asynchronous and synchronised here.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
module serial_port_core
    import serial_port_pkg::*;
#(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // Bus clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial pins
    input wire logic serial_in_line,
    output logic serial_out_line,
    input wire logic flow_permit_in_n,
    output logic flow_request_out_n,
    // Interrupt and DMA
    output logic irq,
    output logic tx_dma_req,
    output logic rx_dma_req
);
    import serial_port_pkg::*;

    // ------------------------------------------------------------------
    // Registers and shared signals
    // ------------------------------------------------------------------
    logic [15:0] div_int_r;
    logic [5:0] div_frac_r;
    logic [7:0] line_ctrl_r;
    logic [15:0] ctrl_r;
    logic [IRQ_BITS-1:0] int_mask_r, int_raw_r, int_set;
    logic [1:0] dma_ctrl_r;
    logic [3:0] err_stat_r;
    logic ph_r, done_r, ph_write_r;
    logic [7:0] ph_addr_r;
    logic bus_wr, bus_rd;
    logic [1:0] rx_meta_r, cts_meta_r;
    logic rxd_s, cts_ok;
    logic tick;
    logic fifo_en;
    logic [3:0] nbits;
    logic [AW:0] limit;

    assign fifo_en = line_ctrl_r[LC_FIFO_EN];
    assign nbits = 4'd5 + {2'b00, line_ctrl_r[LC_WLEN_LO+1:LC_WLEN_LO]};
    assign limit = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_meta_r <= 2'b11;
            cts_meta_r <= 2'b11;
        end else begin
            rx_meta_r <= {rx_meta_r[0], serial_in_line};
            cts_meta_r <= {cts_meta_r[0], flow_permit_in_n};
        end
    end
    assign rxd_s = rx_meta_r[1];
    assign cts_ok = ~ctrl_r[CT_CTS_FLOW] | ~cts_meta_r[1];

    // ------------------------------------------------------------------
    // Fractional rate generator
    // ------------------------------------------------------------------
    // Period alternates between N and N+1 clocks so the average is N+F/64;
    // divisor 1 gives a tick every clock, hence clock/16 baud at most.
    logic [15:0] div_cnt_r;
    logic [5:0] frac_acc_r;
    logic [6:0] frac_sum;
    assign frac_sum = {1'b0, frac_acc_r} + {1'b0, div_frac_r};
    assign tick = (div_int_r != 16'h0000) && (div_cnt_r <= 16'h0001);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= 16'h0000;
            frac_acc_r <= 6'h00;
        end else if (tick || div_cnt_r == 16'h0000) begin
            frac_acc_r <= frac_sum[5:0];
            div_cnt_r <= frac_sum[6] ? div_int_r + 16'h0001 : div_int_r;
        end else begin
            div_cnt_r <= div_cnt_r - 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------------
    logic [7:0] tx_mem [DEPTH];
    logic [11:0] rx_mem [DEPTH];
    logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic [AW:0] tx_cnt_r, rx_cnt_r;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic [11:0] rx_word;

    assign tx_full = tx_cnt_r >= limit;
    assign rx_full = rx_cnt_r >= limit;
    assign tx_empty = tx_cnt_r == '0;
    assign rx_empty = rx_cnt_r == '0;
    assign tx_push = bus_wr && ph_addr_r == OFS_DATA && !tx_full;
    assign rx_pop = bus_rd && ph_addr_r == OFS_DATA && !rx_empty;

    always_ff @(posedge hclk) begin
        if (tx_push) begin
            tx_mem[tx_wp_r] <= hwdata[7:0];
        end
        if (rx_push) begin
            rx_mem[rx_wp_r] <= rx_word;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
            tx_cnt_r <= '0;
            rx_wp_r <= '0;
            rx_rp_r <= '0;
            rx_cnt_r <= '0;
        end else begin
            tx_wp_r <= tx_wp_r + AW'(tx_push);
            tx_rp_r <= tx_rp_r + AW'(tx_pop);
            tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
            rx_wp_r <= rx_wp_r + AW'(rx_push);
            rx_rp_r <= rx_rp_r + AW'(rx_pop);
            rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    ser_state_e tx_st_r;
    logic [3:0] tx_tk_r;
    logic [2:0] tx_bit_r;
    logic [7:0] tx_sh_r;
    logic tx_par_r, tx_stop2_r, tx_line_r;
    logic tx_go, tx_bit_end;

    assign tx_go = ctrl_r[CT_ENABLE] && ctrl_r[CT_TX_EN] && !tx_empty && cts_ok;
    assign tx_pop = tx_st_r == SER_IDLE && tx_go;
    assign tx_bit_end = tick && tx_tk_r == 4'(TICKS_PER_BIT - 1);
    assign serial_out_line = tx_line_r & ~line_ctrl_r[LC_BREAK];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_st_r <= SER_IDLE;
            tx_tk_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_par_r <= 1'b0;
            tx_stop2_r <= 1'b0;
            tx_line_r <= 1'b1;
        end else begin
            if (tick) begin
                tx_tk_r <= tx_tk_r + 4'h1;
            end
            unique case (tx_st_r)
                SER_IDLE: begin
                    tx_line_r <= 1'b1;
                    if (tx_go) begin
                        tx_sh_r <= tx_mem[tx_rp_r];
                        tx_par_r <= ~line_ctrl_r[LC_PAR_EVEN];
                        tx_tk_r <= 4'h0;
                        tx_bit_r <= 3'h0;
                        tx_line_r <= 1'b0;
                        tx_st_r <= SER_START;
                    end
                end
                SER_START: begin
                    if (tx_bit_end) begin
                        tx_line_r <= tx_sh_r[0];
                        tx_st_r <= SER_DATA;
                    end
                end
                SER_DATA: begin
                    if (tx_bit_end) begin
                        tx_par_r <= tx_par_r ^ tx_sh_r[0];
                        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 3'h1;
                        if ({1'b0, tx_bit_r} == nbits - 4'h1) begin
                            if (line_ctrl_r[LC_PAR_EN]) begin
                                tx_line_r <= tx_par_r ^ tx_sh_r[0];
                                tx_st_r <= SER_PARITY;
                            end else begin
                                tx_line_r <= 1'b1;
                                tx_stop2_r <= line_ctrl_r[LC_TWO_STOP];
                                tx_st_r <= SER_STOP;
                            end
                        end else begin
                            tx_line_r <= tx_sh_r[1];
                        end
                    end
                end
                SER_PARITY: begin
                    if (tx_bit_end) begin
                        tx_line_r <= 1'b1;
                        tx_stop2_r <= line_ctrl_r[LC_TWO_STOP];
                        tx_st_r <= SER_STOP;
                    end
                end
                SER_STOP: begin
                    if (tx_bit_end) begin
                        if (tx_stop2_r) begin
                            tx_stop2_r <= 1'b0;
                        end else begin
                            tx_st_r <= SER_IDLE;
                        end
                    end
                end
                default: tx_st_r <= SER_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    ser_state_e rx_st_r;
    logic [3:0] rx_tk_r;
    logic [2:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_par_r, rx_pe_r, ovr_pend_r, rx_done;
    logic [7:0] rx_data;
    logic rx_fe, rx_be, rx_smp;

    assign rx_smp = tick && rx_tk_r == 4'(TICKS_PER_BIT - 1);
    assign rx_data = rx_sh_r >> (4'd8 - nbits);
    assign rx_done = rx_st_r == SER_STOP && rx_smp;
    assign rx_fe = ~rxd_s;
    assign rx_be = rx_fe && rx_data == 8'h00 && !(line_ctrl_r[LC_PAR_EN] && rx_par_r);
    assign rx_push = rx_done && !rx_full;
    assign rx_word = {ovr_pend_r, rx_be, rx_pe_r, rx_fe, rx_data};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_st_r <= SER_IDLE;
            rx_tk_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_pe_r <= 1'b0;
        end else begin
            if (tick) begin
                rx_tk_r <= rx_tk_r + 4'h1;
            end
            unique case (rx_st_r)
                SER_IDLE: begin
                    rx_tk_r <= 4'h0;
                    if (!rxd_s && ctrl_r[CT_ENABLE] && ctrl_r[CT_RX_EN]) begin
                        rx_st_r <= SER_START;
                    end
                end
                SER_START: begin
                    if (tick && rx_tk_r == 4'(START_CHECK_TICK - 1)) begin
                        rx_tk_r <= 4'h0;
                        rx_bit_r <= 3'h0;
                        rx_par_r <= 1'b0;
                        rx_st_r <= rxd_s ? SER_IDLE : SER_DATA;
                    end
                end
                SER_DATA: begin
                    if (rx_smp) begin
                        rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
                        rx_par_r <= rx_par_r ^ rxd_s;
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if ({1'b0, rx_bit_r} == nbits - 4'h1) begin
                            rx_pe_r <= 1'b0;
                            rx_st_r <= line_ctrl_r[LC_PAR_EN] ? SER_PARITY : SER_STOP;
                        end
                    end
                end
                SER_PARITY: begin
                    if (rx_smp) begin
                        // Even parity expects an even count of ones including this bit
                        rx_pe_r <= (rx_par_r ^ rxd_s) != line_ctrl_r[LC_PAR_EVEN] ? 1'b0
                                                                               : 1'b1;
                        rx_par_r <= rxd_s;
                        rx_st_r <= SER_STOP;
                    end
                end
                SER_STOP: begin
                    if (rx_smp) begin
                        rx_st_r <= SER_IDLE;
                    end
                end
                default: rx_st_r <= SER_IDLE;
            endcase
        end
    end

    // Overrun: the character in the shifter is dropped, queued data kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovr_pend_r <= 1'b0;
        end else if (rx_done && rx_full) begin
            ovr_pend_r <= 1'b1;
        end else if (rx_push) begin
            ovr_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Receive timeout
    // ------------------------------------------------------------------
    logic [9:0] rt_cnt_r;
    logic rt_evt;
    assign rt_evt = tick && rt_cnt_r == 10'(RX_TIMEOUT_TICKS - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rt_cnt_r <= 10'h000;
        end else if (rx_empty || rx_push || rx_pop || rx_st_r != SER_IDLE) begin
            rt_cnt_r <= 10'h000;
        end else if (tick && rt_cnt_r != 10'(RX_TIMEOUT_TICKS)) begin
            rt_cnt_r <= rt_cnt_r + 10'h001;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts, flow control, DMA
    // ------------------------------------------------------------------
    logic tx_empty_d_r, cts_d_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_empty_d_r <= 1'b1;
            cts_d_r <= 1'b1;
        end else begin
            tx_empty_d_r <= tx_empty;
            cts_d_r <= cts_meta_r[1];
        end
    end
    always_comb begin
        int_set = '0;
        int_set[IRQ_MS] = cts_d_r != cts_meta_r[1];
        int_set[IRQ_RX] = rx_push;
        int_set[IRQ_TX] = tx_empty && !tx_empty_d_r;
        int_set[IRQ_RT] = rt_evt;
        int_set[IRQ_FE+2:IRQ_FE] = {3{rx_push}} & rx_word[10:8];
        int_set[IRQ_OE] = rx_done && rx_full;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_raw_r <= '0;
        end else begin
            // A new event wins over a clear in the same cycle
            int_raw_r <= (int_raw_r & ~((bus_wr && ph_addr_r == OFS_INT_CLEAR)
                          ? hwdata[IRQ_BITS-1:0] : '0)) | int_set;
        end
    end
    assign irq = |(int_raw_r & int_mask_r);
    assign flow_request_out_n = ctrl_r[CT_RTS_FLOW] ? rx_full : ~ctrl_r[CT_RTS];
    assign tx_dma_req = dma_ctrl_r[0] && !tx_full;
    assign rx_dma_req = dma_ctrl_r[1] && !rx_empty;

    // ------------------------------------------------------------------
    // AHB-Lite slave: one wait state per transfer
    // ------------------------------------------------------------------
    assign hreadyout = ~(ph_r & ~done_r);
    assign hresp = 1'b0;
    assign bus_wr = ph_r && !done_r && ph_write_r;
    assign bus_rd = ph_r && !done_r && !ph_write_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r <= 1'b0;
            done_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end else if (hready) begin
            ph_r <= hsel && htrans[1];
            done_r <= 1'b0;
            ph_write_r <= hwrite;
            ph_addr_r <= {haddr[7:2], 2'b00};
        end else if (ph_r) begin
            done_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_int_r <= DIV_INT_RST;
            div_frac_r <= DIV_FRAC_RST;
            line_ctrl_r <= LINE_CTRL_RST;
            ctrl_r <= CTRL_RST;
            int_mask_r <= '0;
            dma_ctrl_r <= 2'b00;
        end else if (bus_wr) begin
            unique case (ph_addr_r)
                OFS_DIV_INT: div_int_r <= hwdata[15:0];
                OFS_DIV_FRAC: div_frac_r <= hwdata[5:0];
                OFS_LINE_CTRL: line_ctrl_r <= hwdata[7:0];
                OFS_CTRL: ctrl_r <= hwdata[15:0];
                OFS_INT_MASK: int_mask_r <= hwdata[IRQ_BITS-1:0];
                OFS_DMA_CTRL: dma_ctrl_r <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // Sticky error status; hardware setting wins over a clear by write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_stat_r <= 4'h0;
        end else begin
            err_stat_r <= (err_stat_r & ~((bus_wr && ph_addr_r == OFS_STATUS)
                           ? hwdata[11:8] : 4'h0)) | int_set[IRQ_OE:IRQ_FE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_rd) begin
            unique case (ph_addr_r)
                OFS_DATA: hrdata <= {20'h00000, rx_empty ? 12'h000 : rx_mem[rx_rp_r]};
                OFS_STATUS: hrdata <= {20'h00000, err_stat_r, ~tx_empty_d_r & tx_empty,
                                       rx_full, tx_full, rx_empty,
                                       tx_st_r != SER_IDLE || !tx_empty, 2'b00,
                                       ~cts_meta_r[1]};
                OFS_DIV_INT: hrdata <= {16'h0000, div_int_r};
                OFS_DIV_FRAC: hrdata <= {26'h0000000, div_frac_r};
                OFS_LINE_CTRL: hrdata <= {24'h000000, line_ctrl_r};
                OFS_CTRL: hrdata <= {16'h0000, ctrl_r};
                OFS_INT_MASK: hrdata <= {24'h000000, int_mask_r};
                OFS_INT_RAW: hrdata <= {24'h000000, int_raw_r};
                OFS_INT_MASKED: hrdata <= {24'h000000, int_raw_r & int_mask_r};
                OFS_DMA_CTRL: hrdata <= {30'h00000000, dma_ctrl_r};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
    // Only plain async framing exists: CTS/RTS is the only modem-control path, and there is no infrared path.
    // Serial timing is an enable train on the bus clock, no second domain.

endmodule

// file: serial_peer.sv
// Far-end serial peer: 8N1 frames, 16 clocks a bit.
// Assumes a rate divisor of one on the core side.
module serial_peer (
    // Pins
    input wire logic clk,
    input wire logic dut_tx,
    input wire logic rts_n,
    output logic rx_line,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial rx_line = 1'b1;
    initial cts_n = 1'b0;
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        while (rts_n !== 1'b0) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (16) @(posedge clk);
        end
        rx_line <= 1'b1;
    endtask
    // Mid-bit sampling, so edge jitter of a few clocks is tolerated
    task automatic grab(output logic [7:0] b);
        @(negedge dut_tx);
        repeat (24) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = dut_tx;
            repeat (16) @(posedge clk);
        end
    endtask
endmodule

// file: serial_port_core_props.sv
// Checker on the core's pins: bus handshake, read data, reset state, bits.
// Assumes hready is hreadyout and the rate divisor is at least one.
module serial_port_core_props (
    // Watched pins
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic serial_out_line,
    input wire logic flow_request_out_n,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_r <= 1'b0;
        end else begin
            rd_r <= hsel && htrans[1] && hready && !hwrite;
        end
    end
    sequence take_s; hsel && htrans[1] && hready; endsequence
    sequence wait_s; !hreadyout ##1 hreadyout; endsequence
    okay_resp_a: assert property (!hresp) else $error("resp");
    take_wait_a: assert property (take_s |=> wait_s) else $error("wait");
    wait_one_a: assert property (!hreadyout |=> hreadyout) else $error("long");
    wait_cause_a: assert property ($fell(hreadyout) |-> $past(hsel && htrans[1] && hready))
        else $error("stray");
    rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_r)) else $error("rd");
    reset_state_a: assert property ($rose(hresetn) |-> serial_out_line && flow_request_out_n
        && !irq) else $error("rst");
    low_bit_a: assert property ($fell(serial_out_line) |-> !serial_out_line[*8])
        else $error("low");
    high_bit_a: assert property ($rose(serial_out_line) |-> serial_out_line[*8])
        else $error("high");
endmodule
bind serial_port_core serial_port_core_props u_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .serial_out_line(serial_out_line),
    .flow_request_out_n(flow_request_out_n), .irq(irq));

// file: test_async_serial_port_core.sv
// Bench for the core: bus setup, transmit, receive, errors, interrupt.
// Assumes the peer model and the checker are compiled first.
module test_async_serial_port_core;
    import serial_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, txd, rxd, cts_n, rts_n;
    logic txdma, rxdma;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] got;
    int n_errors, checks_done, cyc;
    serial_port_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_in_line(rxd),
        .serial_out_line(txd), .flow_permit_in_n(cts_n), .flow_request_out_n(rts_n),
        .irq(irq), .tx_dma_req(txdma), .rx_dma_req(rxdma));
    serial_peer u_peer (.clk(hclk), .dut_tx(txd), .rts_n(rts_n), .rx_line(rxd), .cts_n(cts_n));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask
    // Ready is looked at mid-cycle so the edge's own updates never race us
    task automatic wait_ready();
        logic ok;
        do begin
            @(negedge hclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge hclk);
        end while (ok !== 1'b1);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
    endtask
    task automatic wait_rx();
        rd = 32'h10;
        for (int i = 0; i < 40 && rd[4]; i++) bus(1'b0, OFS_STATUS, 32'h0);
    endtask
    task automatic t_setup();
        bus(1'b1, OFS_DIV_INT, 32'h1);
        bus(1'b1, OFS_LINE_CTRL, 32'h70);
        bus(1'b1, OFS_INT_MASK, 32'h2);
        bus(1'b1, OFS_DMA_CTRL, 32'h3);
        bus(1'b1, OFS_CTRL, 32'hB01);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("ctrl", rd, 32'hB01);
        bus(1'b0, 8'h3C, 32'h0);
        check("unmapped", rd, 32'h0);
        check("tx dma", {31'h0, txdma}, 32'h1);
        $display("setup done");
    endtask
    task automatic t_tx();
        fork
            u_peer.grab(got);
            bus(1'b1, OFS_DATA, 32'hA5);
        join
        check("tx byte", {24'h0, got}, 32'hA5);
        bus(1'b1, OFS_LINE_CTRL, 32'h76);
        fork
            u_peer.grab(got);
            bus(1'b1, OFS_DATA, 32'h07);
        join
        check("tx parity byte", {24'h0, got}, 32'h07);
        check("tx even parity", {31'h0, txd}, 32'h1);
        bus(1'b1, OFS_LINE_CTRL, 32'h70);
        $display("tx done");
    endtask
    task automatic t_rx();
        check("irq idle", {31'h0, irq}, 32'h0);
        u_peer.send(8'h3C, 1'b1);
        wait_rx();
        check("irq rx", {31'h0, irq}, 32'h1);
        check("rx dma", {31'h0, rxdma}, 32'h1);
        bus(1'b0, OFS_DATA, 32'h0);
        check("rx data", rd, 32'h3C);
        check("rx dma off", {31'h0, rxdma}, 32'h0);
        bus(1'b1, OFS_INT_CLEAR, 32'h2);
        check("irq clear", {31'h0, irq}, 32'h0);
        u_peer.send(8'h81, 1'b0);
        wait_rx();
        bus(1'b0, OFS_DATA, 32'h0);
        check("rx framing", rd, 32'h181);
        $display("rx done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_setup();
        t_tx();
        t_rx();
        give_verdict();
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
endmodule
